// *** clkio_cfg_pkg.sv ***
package clkio_cfg_pkg;

  // Register word and bus geometry
  localparam int          REG_W        = 16;
  localparam int          IDX_W        = 10;
  localparam int          IDX_LSB      = 2;

  // Register indexes; byte address is four times the index
  localparam logic [9:0]  IDX_SLOW_RATE = 10'h16f;
  localparam logic [9:0]  IDX_IO_CLK    = 10'h170;
  localparam logic [9:0]  IDX_UNLOCK    = 10'h0c6;

  // Field positions
  localparam int          RATE_OFF_BIT = 7;
  localparam int          CLK_SEL_LSB  = 8;
  localparam int          CLK_SEL_MSB  = 12;
  localparam int          CLK_OFF_BIT  = 6;
  localparam int          IMP_LSB      = 1;
  localparam int          IMP_MSB      = 4;

  // Writable masks and reset values
  localparam logic [15:0] SLOW_RATE_WMASK = 16'h00ff;
  localparam logic [15:0] SLOW_RATE_RST   = 16'h0115;
  localparam logic [15:0] IO_CLK_WMASK    = 16'h007f;
  localparam logic [15:0] IO_CLK_RST      = 16'h0c50;
  localparam logic [15:0] UNLOCK_RST      = 16'h0000;
  localparam logic [15:0] UNLOCK_KEY      = 16'h0010;

  // Clock output source codes
  localparam logic [4:0]  SEL_RX_A    = 5'h00;
  localparam logic [4:0]  SEL_RX_D    = 5'h03;
  localparam logic [4:0]  SEL_RXDIV_A = 5'h04;
  localparam logic [4:0]  SEL_RXDIV_D = 5'h07;
  localparam logic [4:0]  SEL_TX_A    = 5'h08;
  localparam logic [4:0]  SEL_TX_D    = 5'h0b;
  localparam logic [4:0]  SEL_REF     = 5'h0c;

  // Receive clock divider
  localparam logic [2:0]  DIV_LAST = 3'h4;
  localparam logic [2:0]  DIV_HIGH = 3'h2;

  // AHB-Lite encodings
  localparam logic [1:0]  HRESP_OKAY = 2'h0;
  localparam logic        HRESP_OK1  = 1'b0;

  typedef struct packed {
    logic       off;
    logic [4:0] sel;
  } clkout_cfg_t;

  typedef enum logic [1:0] {
    CAP_SYNC1,
    CAP_SYNC2,
    CAP_LOAD,
    CAP_DONE
  } cap_state_t;

endpackage

// *** clkout_select.sv ***
`timescale 1ns/1ps
`default_nettype none

module clkout_select
  import clkio_cfg_pkg::*;
(
  // Clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // Clock sources
  input  wire logic [3:0]  rx_clk_src,
  input  wire logic [3:0]  tx_clk_src,
  input  wire logic        ref_clk_src,
  // Selection
  input  wire clkout_cfg_t cfg,
  // Pin
  output logic             clk_out_o,
  output logic             clk_out_oe
);

  logic [8:0] src_s1_r;
  logic [8:0] src_s2_r;
  logic [3:0] rx_prev_r;
  logic [2:0] div_r;
  logic [2:0] div_nxt;
  logic       clk_r;
  logic       clk_nxt;
  logic       oe_r;
  logic       oe_nxt;
  logic [1:0] ch;
  logic       rise;

  ////////////////////////////////////////////////////////////////////////
  always_comb begin
    ch      = cfg.sel[1:0];
    rise    = src_s2_r[ch] & ~rx_prev_r[ch];
    div_nxt = div_r;
    if (rise) begin
      div_nxt = (div_r == DIV_LAST) ? 3'h0 : div_r + 3'h1;
    end
    oe_nxt  = ~cfg.off;
    clk_nxt = 1'b0;
    if (cfg.sel <= SEL_RX_D) begin
      clk_nxt = src_s2_r[ch];
    end else if (cfg.sel <= SEL_RXDIV_D) begin
      clk_nxt = (div_r < DIV_HIGH);
    end else if (cfg.sel <= SEL_TX_D) begin
      clk_nxt = src_s2_r[4 + ch];
    end else if (cfg.sel == SEL_REF) begin
      clk_nxt = src_s2_r[8];
    end
    if (cfg.off) begin
      clk_nxt = 1'b0;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      src_s1_r  <= 9'h000;
      src_s2_r  <= 9'h000;
      rx_prev_r <= 4'h0;
      div_r     <= 3'h0;
      clk_r     <= 1'b0;
      oe_r      <= 1'b0;
    end else begin
      src_s1_r  <= {ref_clk_src, tx_clk_src, rx_clk_src};
      src_s2_r  <= src_s1_r;
      rx_prev_r <= src_s2_r[3:0];
      div_r     <= div_nxt;
      clk_r     <= clk_nxt;
      oe_r      <= oe_nxt;
    end
  end

  assign clk_out_o  = clk_r;
  assign clk_out_oe = oe_r;

endmodule

`default_nettype wire

// *** clkio_cfg_regs.sv ***
// Notes on behaviour
// - Rate-adapt-off bit 0 enables adaptation, resets 0
// - Select codes 0-3 pick receive clocks A-D
// - Codes 4-7 pick receive clocks divided by five
// - Codes 8-B pick transmit clocks A-D
// - Code C, reset value, picks crystal reference
// - Clock-off bit gates pin drive; strap sets reset
// - Impedance field: 16 steps, 1111 lowest
// - Impedance reset comes from trim, not constant
//
// Our own choice: the AHB-Lite slave port.
`timescale 1ns/1ps
`default_nettype none

module clkio_cfg_regs
  import clkio_cfg_pkg::*;
(
  // Clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  // Straps and trim
  input  wire logic        clk_out_off_strap,
  input  wire logic [3:0]  impedance_trim,
  // Clock sources
  input  wire logic [3:0]  rx_clk_src,
  input  wire logic [3:0]  tx_clk_src,
  input  wire logic        ref_clk_src,
  // Controls out
  output logic             rate_adapt_en,
  output logic [3:0]       mac_io_drive_impedance,
  output logic             clk_out_o,
  output logic             clk_out_oe
);

  logic [15:0]  slow_r;
  logic [15:0]  slow_nxt;
  logic [15:0]  io_r;
  logic [15:0]  io_nxt;
  logic [15:0]  unlock_r;
  logic [15:0]  unlock_nxt;
  logic         dp_wr_r;
  logic         dp_wr_nxt;
  logic [9:0]   dp_idx_r;
  logic [9:0]   dp_idx_nxt;
  logic [31:0]  rdata_r;
  logic [31:0]  rdata_nxt;
  logic         off_s1_r;
  logic         off_s2_r;
  logic [3:0]   trim_s1_r;
  logic [3:0]   trim_s2_r;
  cap_state_t   cap_r;
  cap_state_t   cap_nxt;
  logic         req;
  logic [4:0]   sel_wr;
  clkout_cfg_t  clk_cfg;

  ////////////////////////////////////////////////////////////////////////
  function automatic logic [15:0] read_word(input logic [9:0]  idx,
                                            input logic [15:0] slow,
                                            input logic [15:0] io,
                                            input logic [15:0] unlock);
    logic [15:0] v;
    v = 16'h0000;
    unique case (idx)
      IDX_SLOW_RATE: v = slow & SLOW_RATE_WMASK;
      IDX_IO_CLK:    v = io & (IO_CLK_WMASK | 16'h1f00);
      IDX_UNLOCK:    v = unlock;
      default:       v = 16'h0000;
    endcase
    return v;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Strap and trim capture after reset release
  always_comb begin
    cap_nxt = cap_r;
    unique case (cap_r)
      CAP_SYNC1: cap_nxt = CAP_SYNC2;
      CAP_SYNC2: cap_nxt = CAP_LOAD;
      CAP_LOAD:  cap_nxt = CAP_DONE;
      CAP_DONE:  cap_nxt = CAP_DONE;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cap_r     <= CAP_SYNC1;
      off_s1_r  <= 1'b1;
      off_s2_r  <= 1'b1;
      trim_s1_r <= 4'h8;
      trim_s2_r <= 4'h8;
    end else begin
      cap_r     <= cap_nxt;
      off_s1_r  <= clk_out_off_strap;
      off_s2_r  <= off_s1_r;
      trim_s1_r <= impedance_trim;
      trim_s2_r <= trim_s1_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Bus phases and register updates
  always_comb begin
    req        = hsel & hready & htrans[1];
    dp_wr_nxt  = req & hwrite;
    dp_idx_nxt = req ? haddr[IDX_LSB +: IDX_W] : dp_idx_r;
    slow_nxt   = slow_r;
    io_nxt     = io_r;
    unlock_nxt = unlock_r;
    sel_wr     = hwdata[CLK_SEL_MSB:CLK_SEL_LSB];
    if (cap_r == CAP_LOAD) begin
      io_nxt[CLK_OFF_BIT]     = off_s2_r;
      io_nxt[IMP_MSB:IMP_LSB] = trim_s2_r;
    end
    if (dp_wr_r) begin
      unique case (dp_idx_r)
        IDX_SLOW_RATE: slow_nxt = hwdata[15:0] & SLOW_RATE_WMASK;
        IDX_IO_CLK: begin
          io_nxt = (io_r & ~IO_CLK_WMASK) | (hwdata[15:0] & IO_CLK_WMASK);
          if (unlock_r == UNLOCK_KEY && sel_wr <= SEL_REF) begin
            io_nxt[CLK_SEL_MSB:CLK_SEL_LSB] = sel_wr;
          end
        end
        IDX_UNLOCK:    unlock_nxt = hwdata[15:0];
        default:       slow_nxt = slow_r;
      endcase
    end
    rdata_nxt = rdata_r;
    if (req && !hwrite) begin
      rdata_nxt = {16'h0000, read_word(haddr[IDX_LSB +: IDX_W], slow_nxt, io_nxt,
                                       unlock_nxt)};
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      slow_r   <= SLOW_RATE_RST;
      io_r     <= IO_CLK_RST;
      unlock_r <= UNLOCK_RST;
      dp_wr_r  <= 1'b0;
      dp_idx_r <= 10'h000;
      rdata_r  <= 32'h0000_0000;
    end else begin
      slow_r   <= slow_nxt;
      io_r     <= io_nxt;
      unlock_r <= unlock_nxt;
      dp_wr_r  <= dp_wr_nxt;
      dp_idx_r <= dp_idx_nxt;
      rdata_r  <= rdata_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  assign hreadyout              = 1'b1;
  assign hresp                  = HRESP_OK1;
  assign hrdata                 = rdata_r;
  assign rate_adapt_en          = ~slow_r[RATE_OFF_BIT];
  assign mac_io_drive_impedance = io_r[IMP_MSB:IMP_LSB];
  assign clk_cfg                = {io_r[CLK_OFF_BIT], io_r[CLK_SEL_MSB:CLK_SEL_LSB]};

  clkout_select u_clkout (
    .hclk        (hclk),
    .hresetn     (hresetn),
    .rx_clk_src  (rx_clk_src),
    .tx_clk_src  (tx_clk_src),
    .ref_clk_src (ref_clk_src),
    .cfg         (clk_cfg),
    .clk_out_o   (clk_out_o),
    .clk_out_oe  (clk_out_oe)
  );

endmodule

`default_nettype wire

// *** clock_out_and_io_config_properties.sv ***
`timescale 1ns/1ps
`default_nettype none
module clkio_cfg_checker
  import clkio_cfg_pkg::*;
(
  // Bus
  input wire logic        hclk,
  input wire logic        hresetn,
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic        hready,
  input wire logic [31:0] hwdata,
  input wire logic [31:0] hrdata,
  // Pins
  input wire logic        clk_out_off_strap,
  input wire logic [3:0]  impedance_trim,
  input wire logic        rate_adapt_en,
  input wire logic [3:0]  mac_io_drive_impedance,
  input wire logic        clk_out_o,
  input wire logic        clk_out_oe
);
  logic       wp_r, rp_r;
  logic [9:0] ix_r;
  logic [2:0] age_r;
  wire        take = hsel && hready && htrans[1];
  wire        mapped = ix_r inside {IDX_SLOW_RATE, IDX_IO_CLK, IDX_UNLOCK};
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  ////////////////////////////////////////
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      {wp_r, rp_r, ix_r, age_r} <= '0;
    end else begin
      wp_r  <= take && hwrite;
      rp_r  <= take && !hwrite;
      ix_r  <= haddr[11:2];
      age_r <= age_r + {2'h0, age_r != 3'h7};
    end
  end
  ////////////////////////////////////////
  sequence s_slow_wr; wp_r && ix_r == IDX_SLOW_RATE; endsequence
  sequence s_io_wr; wp_r && ix_r == IDX_IO_CLK; endsequence
  chk_rate_write: assert property (s_slow_wr |=> rate_adapt_en == !$past(hwdata[7]))
    else $error("rate enable wrong");
  chk_imp_write: assert property (s_io_wr |=> mac_io_drive_impedance == $past(hwdata[4:1]))
    else $error("impedance wrong");
  chk_oe_write: assert property (s_io_wr |=> ##1 clk_out_oe == !$past(hwdata[6], 2))
    else $error("pin enable wrong");
  chk_pin_quiet: assert property (!clk_out_oe |-> !clk_out_o)
    else $error("pin toggles while off");
  chk_trim_load: assert property (age_r == 3'h4 |-> mac_io_drive_impedance == impedance_trim)
    else $error("trim not loaded");
  chk_strap_load: assert property (age_r == 3'h4 |-> clk_out_oe == !clk_out_off_strap)
    else $error("strap not loaded");
  chk_rsv_zero: assert property (rp_r && ix_r == IDX_SLOW_RATE |-> hrdata[31:8] == '0)
    else $error("reserved bits set");
  chk_unmapped_zero: assert property (rp_r && !mapped |-> hrdata == '0)
    else $error("unmapped read not zero");
endmodule
bind clkio_cfg_regs clkio_cfg_checker u_chk (.*);
`default_nettype wire

// *** clock_out_and_io_config_tb.sv ***
`timescale 1ns/1ps
`default_nettype none
module clock_out_and_io_config_tb
  import clkio_cfg_pkg::*;
;
  localparam logic [31:0] A_SLOW = 32'h0000_05bc;
  localparam logic [31:0] A_IO   = 32'h0000_05c0;
  logic        hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, strap = 0, ref_c = 0;
  logic [1:0]  htrans = 2'h0;
  logic [2:0]  hsize = 3'h2;
  logic [3:0]  trim = 4'h0, rx = 4'h0, tx = 4'h0, imp;
  logic [31:0] haddr = '0, hwdata = '0, hrdata, d, r;
  logic        hreadyout, hresp, rate_en, clko, oe;
  int          n_errors = 0;
  int          tests_run = 0;
  always #4 hclk = ~hclk;
  clkio_cfg_regs u_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .clk_out_off_strap(strap),
    .impedance_trim(trim), .rx_clk_src(rx), .tx_clk_src(tx), .ref_clk_src(ref_c),
    .rate_adapt_en(rate_en), .mac_io_drive_impedance(imp), .clk_out_o(clko), .clk_out_oe(oe));
  ////////////////////////////////////////
  task automatic test_done;
    if (n_errors == 0 && tests_run > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      n_errors++;
      $display("BAD %0t exp %h got %h", $time, e, g);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge hclk);
    #1;
  endtask
  task automatic wrdy;
    int k;
    k = 0;
    do begin @(posedge hclk); k++; end while (hreadyout !== 1'b1 && k < 100);
    if (k >= 100) begin
      n_errors++;
      test_done;
    end
  endtask
  task automatic bus(input logic w, input logic [31:0] a, d, output logic [31:0] q);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    wrdy;
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    wrdy;
    q = hrdata;
  endtask
  function automatic logic [31:0] io_exp(input logic [4:0] s, input logic [6:0] lo);
    return {19'h0, s, 1'b0, lo};
  endfunction
  task automatic lvl_chk(input int c, input logic v);
    @(posedge hclk);
    rx <= {4{!v}} ^ ((c < 4) ? 4'h1 << c : 4'h0);
    tx <= {4{!v}} ^ ((c > 7 && c < 12) ? 4'h1 << (c - 8) : 4'h0);
    ref_c <= (c == 12) ? v : !v;
    cyc(6);
    chk(v, clko);
  endtask
  task automatic div_chk(input int k);
    int n_up;
    logic last;
    n_up = 0;
    last = clko;
    for (int i = 0; i < 240; i++) begin
      @(posedge hclk);
      rx <= (i % 16 < 8) ? 4'h1 << k : 4'h0;
      #1;
      n_up += int'(clko && !last);
      last = clko;
    end
    chk(3, n_up);
  endtask
  ////////////////////////////////////////
  initial begin
    d = $urandom(40478);
    strap <= d[0];
    trim <= d[4:1];
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    cyc(8);
    chk(1, rate_en);
    chk(trim, imp);
    chk(!strap, oe);
    bus(0, A_SLOW, '0, r);
    chk(32'h0000_0015, r);
    bus(0, A_IO, '0, r);
    chk(io_exp(5'h0c, {strap, 1'b0, trim, 1'b0}), r);
    repeat (4) begin
      d = $urandom;
      bus(1, A_SLOW, d, r);
      bus(0, A_SLOW, '0, r);
      chk(d & 32'h0000_00ff, r);
      chk(!d[7], rate_en);
    end
    d = $urandom;
    bus(1, A_IO, {d[31:13], 5'h03, d[7:0]}, r);
    bus(0, A_IO, '0, r);
    chk(io_exp(5'h0c, d[6:0]), r);
    chk(d[4:1], imp);
    bus(1, 32'h0000_0318, 32'h0000_0010, r);
    bus(0, 32'h0000_0318, '0, r);
    chk(32'h0000_0010, r);
    for (int c = 0; c <= 12; c++) begin
      bus(1, A_IO, {19'h0, c[4:0], 8'h10}, r);
      bus(0, A_IO, '0, r);
      chk(io_exp(c[4:0], 7'h10), r);
      if (c inside {[4:7]})
        div_chk(c - 4);
      else
        for (int v = 0; v < 2; v++)
          lvl_chk(c, v[0]);
    end
    bus(1, A_IO, 32'h0000_0d5e, r);
    bus(0, A_IO, '0, r);
    chk(io_exp(5'h0c, 7'h5e), r);
    cyc(2);
    chk(0, oe);
    chk(0, clko);
    chk(4'hf, imp);
    bus(1, 32'h0000_0004, $urandom, r);
    bus(0, 32'h0000_0004, '0, r);
    chk(0, r);
    chk(0, hresp);
    chk(1, hreadyout);
    test_done;
  end
endmodule
`default_nettype wire
